// ===== shared/cam_consts.svh
// Function
// - Six independent modes; PWM shares cycle length
// - Enabled flag raises the interrupt request
// - Cycle overflow interrupt enable, length selected
// - Comparator off: pin holds, PWM low
// - View bit picks compare or reload register
// - Match enable lets matches set flag
// - Length select codes 8 to 11 bits
// - Capture copies counter, sets flag
// - Rising, falling or both edges capture
// - Flag cleared only by software zero write
// - Timer sets flag on 16-bit equality
// - Low write clears, high write sets comparator
// - High-speed mode toggles pin on match
// - Frequency mode toggles, adds high to low
// - High byte zero means 256 counts
// - Frequency mode flag on full equality
// - 8-bit PWM: high on match, low overflow
// - 8-bit PWM reloads low from high byte
// - 8-bit PWM selection, flag, overflow mark
// - 8-bit duty from high byte value
// - Wider PWM: N-bit match, overflow reload
// - 16-bit PWM: match high, overflow low
// - Cycle overflow flag from bit N overflow
`ifndef CAM_CONSTS_SVH
`define CAM_CONSTS_SVH

`define CAM_MODE_OFS 8'h00
`define CAM_CMPL_OFS 8'h04
`define CAM_CMPH_OFS 8'h08
`define CAM_CFG_OFS 8'h0c
`define CAM_STAT_OFS 8'h10

`define CAM_B_WIDE 7
`define CAM_B_CMP 6
`define CAM_B_RISE 5
`define CAM_B_FALL 4
`define CAM_B_MAT 3
`define CAM_B_TOG 2
`define CAM_B_PULSE 1
`define CAM_B_IRQ 0

`define CAM_B_RVIEW 7
`define CAM_B_CYCLE_OVERFLOW_FLAG 6
`define CAM_B_COVIE 5
`define CAM_SEL_HI 1
`define CAM_SEL_LO 0

`define CAM_B_FLAG 0
`define CAM_B_PIN 1

`define CAM_MODE_RST 8'h00
`define CAM_CMP_RST 16'h0000
`define CAM_SEL_RST 2'h0
`define CAM_PIN_STABLE_CYC 2

`endif

// ===== shared/cam_pkg.sv
`default_nettype none
package cam_pkg;
  typedef enum logic [6:0] {
    CAM_IDLE = 7'h01,
    CAM_CAP = 7'h02,
    CAM_TIMER = 7'h04,
    CAM_HSO = 7'h08,
    CAM_FREQ = 7'h10,
    CAM_PULSE_MODE_ENABLE = 7'h20,
    CAM_PWM16 = 7'h40
  } cam_mode_t;
endpackage
`default_nettype wire

// ===== hw/cam_module.sv
`timescale 1ns/1ps
`default_nettype none
`include "cam_consts.svh"

module cam_module (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] counter_value,
  input wire logic counter_tick,
  input wire logic module_io_pin_in,
  output logic module_io_pin_out,
  output logic module_io_pin_oe,
  output logic cam_irq
);

  function automatic logic [15:0] cam_mask(input logic [1:0] sel);
    case (sel)
      2'h0: cam_mask = 16'h00ff;
      2'h1: cam_mask = 16'h01ff;
      2'h2: cam_mask = 16'h03ff;
      default: cam_mask = 16'h07ff;
    endcase
  endfunction

  function automatic cam_pkg::cam_mode_t cam_decode(input logic [7:0] m);
    if (m[`CAM_B_PULSE] && m[`CAM_B_TOG]) begin
      cam_decode = cam_pkg::CAM_FREQ;
    end else if (m[`CAM_B_PULSE] && m[`CAM_B_WIDE]) begin
      cam_decode = cam_pkg::CAM_PWM16;
    end else if (m[`CAM_B_PULSE]) begin
      cam_decode = cam_pkg::CAM_PULSE_MODE_ENABLE;
    end else if (m[`CAM_B_TOG]) begin
      cam_decode = cam_pkg::CAM_HSO;
    end else if (m[`CAM_B_RISE] || m[`CAM_B_FALL]) begin
      cam_decode = cam_pkg::CAM_CAP;
    end else if (m[`CAM_B_CMP] && m[`CAM_B_MAT]) begin
      cam_decode = cam_pkg::CAM_TIMER;
    end else begin
      cam_decode = cam_pkg::CAM_IDLE;
    end
  endfunction

  logic [7:0] module_mode_reg;
  logic [1:0] cycle_length_select;
  logic reload_view_select;
  logic cycle_overflow_irq_enable;
  logic cycle_overflow_flag;
  logic match_capture_flag;
  logic [15:0] cmp;
  logic [15:0] reload;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic ack;
  logic [31:0] rdata;

  // Bus: one wait cycle, answer on the second
  wire access = avs_read | avs_write;
  wire wr_fire = avs_write & ack & avs_byteenable[0];
  wire [7:0] wdata = avs_writedata[7:0];
  wire wr_mode = wr_fire & (avs_address == `CAM_MODE_OFS);
  wire wr_cmpl = wr_fire & (avs_address == `CAM_CMPL_OFS);
  wire wr_cmph = wr_fire & (avs_address == `CAM_CMPH_OFS);
  wire wr_cfg = wr_fire & (avs_address == `CAM_CFG_OFS);
  wire wr_stat = wr_fire & (avs_address == `CAM_STAT_OFS);

  assign avs_waitrequest = access & ~ack;
  assign avs_readdata = rdata;

  cam_pkg::cam_mode_t mode;
  assign mode = cam_decode(module_mode_reg);

  wire ecom = module_mode_reg[`CAM_B_CMP];
  wire mat = module_mode_reg[`CAM_B_MAT];
  wire [15:0] mask = cam_mask(cycle_length_select);
  wire [15:0] cnt_n = counter_value & mask;
  wire [15:0] cmp_n = cmp & mask;

  // Counter-driven events only on tick cycles
  wire match16 = counter_tick & ecom & (counter_value == cmp);
  wire match_lo = counter_tick & ecom & (counter_value[7:0] == cmp[7:0]);
  wire match_n = counter_tick & ecom & (cnt_n == cmp_n);
  wire ovf_n = counter_tick & (cnt_n == 16'h0000);
  wire ovf16 = counter_tick & (counter_value == 16'h0000);

  // Edge detect on delayed copies; a pulse seen for only one clock still gives an edge
  wire rise_ev = module_mode_reg[`CAM_B_RISE] & pin_s2 & ~pin_s3;
  wire fall_ev = module_mode_reg[`CAM_B_FALL] & ~pin_s2 & pin_s3;
  wire cap_ev = (mode == cam_pkg::CAM_CAP) & (rise_ev | fall_ev);

  wire cmp16_mode = (mode == cam_pkg::CAM_TIMER) | (mode == cam_pkg::CAM_HSO) |
    (mode == cam_pkg::CAM_FREQ) | (mode == cam_pkg::CAM_PWM16);
  wire flag_set = cap_ev | (mat & cmp16_mode & match16) |
    (mat & (mode == cam_pkg::CAM_PULSE_MODE_ENABLE) & match_n);
  wire flag_clr = wr_stat & ~wdata[`CAM_B_FLAG];
  wire next_flag = flag_set | (match_capture_flag & ~flag_clr);

  wire cycle_overflow_flag_clr = wr_cfg & ~wdata[`CAM_B_CYCLE_OVERFLOW_FLAG];
  wire next_cycle_overflow_flag = ovf_n | (cycle_overflow_flag & ~cycle_overflow_flag_clr);

  // Zero high byte adds nothing mod 256, giving a 256 count half period
  wire [7:0] freq_lo = cmp[7:0] + cmp[15:8];

  logic next_pin;
  always_comb begin
    next_pin = module_io_pin_out;
    case (mode)
      cam_pkg::CAM_HSO: if (match16) next_pin = ~module_io_pin_out;
      cam_pkg::CAM_FREQ: if (match_lo) next_pin = ~module_io_pin_out;
      cam_pkg::CAM_PULSE_MODE_ENABLE: begin
        // Match wins over overflow so a zero compare gives full duty
        if (!ecom) next_pin = 1'b0;
        else if (match_n) next_pin = 1'b1;
        else if (ovf_n) next_pin = 1'b0;
      end
      cam_pkg::CAM_PWM16: begin
        if (!ecom) next_pin = 1'b0;
        else if (match16) next_pin = 1'b1;
        else if (ovf16) next_pin = 1'b0;
      end
      default: next_pin = module_io_pin_out;
    endcase
  end

  logic [15:0] next_cmp;
  always_comb begin
    next_cmp = cmp;
    if (cap_ev) begin
      next_cmp = counter_value;
    end else if ((mode == cam_pkg::CAM_FREQ) && match_lo) begin
      next_cmp = {cmp[15:8], freq_lo};
    end else if ((mode == cam_pkg::CAM_PULSE_MODE_ENABLE) && ovf_n) begin
      if (cycle_length_select == `CAM_SEL_RST) next_cmp = {cmp[15:8], cmp[15:8]};
      else next_cmp = reload;
    end
    if (wr_cmpl && !reload_view_select) next_cmp[7:0] = wdata;
    if (wr_cmph && !reload_view_select) next_cmp[15:8] = wdata;
  end

  logic [15:0] next_reload;
  always_comb begin
    next_reload = reload;
    if (wr_cmpl && reload_view_select) next_reload[7:0] = wdata;
    if (wr_cmph && reload_view_select) next_reload[15:8] = wdata;
  end

  logic [7:0] next_mode;
  always_comb begin
    next_mode = module_mode_reg;
    if (wr_mode) next_mode = wdata;
    if (wr_cmpl) next_mode[`CAM_B_CMP] = 1'b0;
    if (wr_cmph) next_mode[`CAM_B_CMP] = 1'b1;
  end

  logic [31:0] next_rdata;
  always_comb begin
    case (avs_address)
      `CAM_MODE_OFS: next_rdata = {24'h000000, module_mode_reg};
      `CAM_CMPL_OFS: next_rdata = {24'h000000, reload_view_select ? reload[7:0] : cmp[7:0]};
      `CAM_CMPH_OFS: next_rdata = {24'h000000, reload_view_select ? reload[15:8] : cmp[15:8]};
      `CAM_CFG_OFS: next_rdata = {24'h000000, reload_view_select, cycle_overflow_flag,
        cycle_overflow_irq_enable, 3'h0, cycle_length_select};
      `CAM_STAT_OFS: next_rdata = {30'h0, pin_s2, match_capture_flag};
      default: next_rdata = 32'h00000000;
    endcase
  end

  assign module_io_pin_oe = (mode == cam_pkg::CAM_HSO) | (mode == cam_pkg::CAM_FREQ) |
    (mode == cam_pkg::CAM_PULSE_MODE_ENABLE) | (mode == cam_pkg::CAM_PWM16);
  assign cam_irq = (match_capture_flag & module_mode_reg[`CAM_B_IRQ]) |
    (cycle_overflow_flag & cycle_overflow_irq_enable);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      ack <= access & ~ack;
      if (access && !ack) rdata <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      module_mode_reg <= `CAM_MODE_RST;
      cmp <= `CAM_CMP_RST;
      reload <= `CAM_CMP_RST;
      module_io_pin_out <= 1'b0;
      match_capture_flag <= 1'b0;
      cycle_overflow_flag <= 1'b0;
    end else begin
      module_mode_reg <= next_mode;
      cmp <= next_cmp;
      reload <= next_reload;
      module_io_pin_out <= next_pin;
      match_capture_flag <= next_flag;
      cycle_overflow_flag <= next_cycle_overflow_flag;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cycle_length_select <= `CAM_SEL_RST;
      reload_view_select <= 1'b0;
      cycle_overflow_irq_enable <= 1'b0;
    end else if (wr_cfg) begin
      cycle_length_select <= wdata[`CAM_SEL_HI:`CAM_SEL_LO];
      reload_view_select <= wdata[`CAM_B_RVIEW];
      cycle_overflow_irq_enable <= wdata[`CAM_B_COVIE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Preload the pin level so a pin idling high gives no false edge
      pin_s1 <= module_io_pin_in;
      pin_s2 <= module_io_pin_in;
      pin_s3 <= module_io_pin_in;
    end else begin
      pin_s1 <= module_io_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  default clocking cam_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence low_write_s;
    wr_cmpl;
  endsequence

  sequence high_write_s;
    wr_cmph;
  endsequence

  sequence quiet_bus_s;
    !wr_cmpl && !wr_cmph;
  endsequence

  sequence pwm_live_s;
    (mode == cam_pkg::CAM_PULSE_MODE_ENABLE) && ecom;
  endsequence

  flag_sticky_a: assert property ($fell(match_capture_flag) |-> $past(flag_clr))
    else $error("flag fell without a software clear");

  capture_load_a: assert property (cap_ev and quiet_bus_s |=>
    (cmp == $past(counter_value)) && match_capture_flag)
    else $error("capture did not load counter and set flag");

  low_clears_a: assert property (low_write_s |=> !module_mode_reg[`CAM_B_CMP])
    else $error("low byte write left comparator enabled");

  high_sets_a: assert property (high_write_s and !wr_mode |=> module_mode_reg[`CAM_B_CMP])
    else $error("high byte write did not enable comparator");

  hso_toggle_a: assert property ((mode == cam_pkg::CAM_HSO) && match16 |=>
    module_io_pin_out != $past(module_io_pin_out))
    else $error("high speed output did not toggle");

  freq_step_a: assert property ((mode == cam_pkg::CAM_FREQ) && match_lo and quiet_bus_s |=>
    cmp[7:0] == $past(freq_lo) ##1 1'b1)
    else $error("frequency step not added");

  pwm_off_a: assert property ((mode == cam_pkg::CAM_PULSE_MODE_ENABLE || mode == cam_pkg::CAM_PWM16)
    && !ecom |=> !module_io_pin_out)
    else $error("pwm output high with comparator off");

  cycle_overflow_flag_set_a: assert property (ovf_n |=> cycle_overflow_flag)
    else $error("cycle overflow flag not set");

  irq_flag_a: assert property (match_capture_flag && module_mode_reg[`CAM_B_IRQ] |-> cam_irq)
    else $error("enabled flag did not raise interrupt");

  pwm8_reload_a: assert property ((mode == cam_pkg::CAM_PULSE_MODE_ENABLE) && ovf_n &&
    (cycle_length_select == 2'h0) && !cap_ev and quiet_bus_s |=>
    cmp[7:0] == $past(cmp[15:8]))
    else $error("8-bit pwm reload missing");

  timer_flag_a: assert property ((mode == cam_pkg::CAM_TIMER) && match16 |=>
    match_capture_flag)
    else $error("timer match did not set flag");

  pwm_rise_a: assert property (pwm_live_s and match_n
    |=> module_io_pin_out)
    else $error("pwm output not raised on match");

  pwm_fall_a: assert property ((mode == cam_pkg::CAM_PULSE_MODE_ENABLE) && ovf_n
    && !match_n |=> !module_io_pin_out)
    else $error("pwm output not lowered on overflow");

  pwm_flag_a: assert property (pwm_live_s and mat && match_n
    |=> match_capture_flag)
    else $error("pwm match did not set flag");

  wide_reload_a: assert property ((mode == cam_pkg::CAM_PULSE_MODE_ENABLE) && ovf_n &&
    (cycle_length_select != 2'h0) and quiet_bus_s |=> cmp == $past(reload))
    else $error("wide pwm reload missing");

  pwm16_rise_a: assert property ((mode == cam_pkg::CAM_PWM16) && match16
    |=> module_io_pin_out)
    else $error("16-bit pwm output not raised");

  pwm16_fall_a: assert property ((mode == cam_pkg::CAM_PWM16) && ovf16
    && !match16 |=> !module_io_pin_out)
    else $error("16-bit pwm output not lowered");

  hso_hold_a: assert property ((mode == cam_pkg::CAM_HSO) && !ecom
    |=> $stable(module_io_pin_out))
    else $error("high speed output moved with comparator off");

  freq_hold_a: assert property ((mode == cam_pkg::CAM_FREQ) && !ecom
    |=> $stable(module_io_pin_out))
    else $error("frequency output moved with comparator off");

  freq_flag_a: assert property ((mode == cam_pkg::CAM_FREQ) && mat && match16
    |=> match_capture_flag)
    else $error("frequency mode match did not set flag");

  freq_zero_a: assert property ((mode == cam_pkg::CAM_FREQ) && match_lo &&
    (cmp[15:8] == 8'h00) and quiet_bus_s |=> $stable(cmp))
    else $error("zero step moved the low byte");

  rise_cap_a: assert property ((mode == cam_pkg::CAM_CAP) && rise_ev
    |=> match_capture_flag)
    else $error("rising edge not captured");

  fall_cap_a: assert property ((mode == cam_pkg::CAM_CAP) && fall_ev
    |=> match_capture_flag)
    else $error("falling edge not captured");

  flag_hold_a: assert property (match_capture_flag && !flag_clr
    |=> match_capture_flag)
    else $error("flag dropped without a zero write");

  cov_irq_a: assert property (cycle_overflow_flag && cycle_overflow_irq_enable
    |-> cam_irq)
    else $error("enabled cycle overflow did not raise interrupt");

  irq_quiet_a: assert property (!match_capture_flag && !cycle_overflow_flag
    |-> !cam_irq)
    else $error("interrupt raised with no flag set");

  tick_only_a: assert property (!counter_tick
    |=> !$rose(cycle_overflow_flag))
    else $error("cycle overflow flag set off a tick");

  tick_pin_a: assert property (!counter_tick && ecom
    |=> $stable(module_io_pin_out))
    else $error("pin moved off a tick");

  low_view_a: assert property (wr_cmpl && !reload_view_select
    |=> cmp[7:0] == $past(wdata))
    else $error("low byte write missed the compare register");

  high_reload_a: assert property (wr_cmph && reload_view_select
    |=> reload[15:8] == $past(wdata))
    else $error("high byte write missed the reload register");

  cfg_len_a: assert property (wr_cfg
    |=> cycle_length_select == $past(wdata[`CAM_SEL_HI:`CAM_SEL_LO]))
    else $error("cycle length not stored");

  cycle_overflow_flag_hold_a: assert property (cycle_overflow_flag && !cycle_overflow_flag_clr
    |=> cycle_overflow_flag)
    else $error("cycle overflow flag dropped on its own");

  bus_answer_a: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request left waiting");

endmodule // cam_module
`default_nettype wire

// ===== verification/cam_pin_ext.sv
`timescale 1ns/1ps
`default_nettype none
module cam_pin_ext (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic want,
  output logic pin_in
);
  logic drv;
  logic [1:0] held;
  // Slower than asked rather than a level held for under two clocks
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drv <= 1'b0;
      held <= 2'h0;
    end else if (want != drv && held != 2'h0) begin
      drv <= want;
      held <= 2'h0;
    end else if (held != 2'h3) begin
      held <= held + 2'h1;
    end
  end
  // Device drive wins while it owns the pin
  assign pin_in = pin_oe ? pin_out : drv;
endmodule // cam_pin_ext
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, wprev, cap, prv;
  logic counter_tick, want, pin_in, pin_out, pin_oe, cam_irq;
  logic [7:0] avs_address, m, h;
  logic [31:0] avs_writedata, avs_readdata, rs;
  logic [3:0] avs_byteenable;
  logic [15:0] counter_value, v;
  logic [7:0] exq[$];
  int n_fail, compares, cyc, hi, tg, k, e;

  cam_module i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .counter_value(counter_value),
    .counter_tick(counter_tick), .module_io_pin_in(pin_in),
    .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe), .cam_irq(cam_irq));
  cam_pin_ext i_pin (.sys_clk(sys_clk), .rst(rst), .pin_out(pin_out),
    .pin_oe(pin_oe), .want(want), .pin_in(pin_in));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    do @(posedge sys_clk); while (wprev !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exq.push_back(x);
    bus(a, 1'b0, 8'h00);
  endtask

  task automatic run(input int n, input int base);
    hi = 0;
    tg = 0;
    // Each sample shows the pin after the previous tick's edge
    for (int i = 0; i <= n; i++) begin
      @(posedge sys_clk);
      counter_value <= 16'(base + i);
      counter_tick <= (i < n);
      @(negedge sys_clk);
      if (i > 0) begin
        hi += int'(pin_out === 1'b1);
        tg += int'(pin_out !== prv);
      end
      prv = pin_out;
    end
  endtask

  // Waitrequest is settled by the falling edge and holds to the next rise
  always @(negedge sys_clk) wprev = avs_waitrequest;

  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exq.size() > 0)
      chk(avs_readdata, {24'h0, exq.pop_front()});
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    counter_value = 16'h0;
    counter_tick = 1'b0;
    want = 1'b0;
    rs = 32'd78130;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h10, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h00, 8'h40);
    wr(8'h04, 8'h12);
    rd(8'h00, 8'h00);
    wr(8'h08, 8'h34);
    rd(8'h00, 8'h40);
    for (k = 0; k < 6; k++) begin
      m = (k < 2) ? 8'h21 : (k < 4) ? 8'h11 : 8'h31;
      wr(8'h00, m);
      v = rnd();
      @(posedge sys_clk);
      counter_value <= v;
      counter_tick <= 1'b1;
      want <= ~want;
      repeat (6) @(posedge sys_clk);
      cap = want ? m[5] : m[4];
      rd(8'h10, {6'h0, want, cap});
      chk({31'h0, cam_irq}, {31'h0, cap});
      if (cap) begin
        rd(8'h04, v[7:0]);
        rd(8'h08, v[15:8]);
      end
      wr(8'h10, 8'h00);
    end
    counter_tick <= 1'b0;
    v = rnd();
    wr(8'h00, 8'h49);
    wr(8'h04, v[7:0]);
    wr(8'h08, v[15:8]);
    run(2, int'(v) - 1);
    rd(8'h10, 8'h01);
    chk({31'h0, cam_irq}, 32'h1);
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h00, 8'h4c);
    wr(8'h04, v[7:0]);
    wr(8'h08, v[15:8]);
    run(2, int'(v) - 1);
    chk(tg, 1);
    wr(8'h00, 8'h42);
    wr(8'h0c, 8'h00);
    for (k = 0; k < 4; k++) begin
      v = rnd();
      h = (k == 0) ? 8'h00 : (k == 1) ? v[7:0] : 8'hff;
      e = (k == 3) ? 0 : 256 - int'(h);
      wr(8'h04, 8'h80);
      if (k < 3)
        wr(8'h08, h);
      run(256, 0);
      run(256, 256);
      chk(hi, e);
      chk({31'h0, pin_oe}, 32'h1);
    end
    rd(8'h0c, 8'h40);
    wr(8'h0c, 8'h60);
    @(negedge sys_clk);
    chk({31'h0, cam_irq}, 32'h1);
    wr(8'h0c, 8'h00);
    @(negedge sys_clk);
    chk({31'h0, cam_irq}, 32'h0);
    wr(8'h0c, 8'h81);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h01);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h01);
    run(512, 0);
    run(512, 512);
    chk(hi, 256);
    wr(8'h0c, 8'h01);
    rd(8'h08, 8'h01);
    wr(8'h00, 8'h46);
    for (k = 0; k < 2; k++) begin
      wr(8'h04, 8'h05);
      wr(8'h08, (k == 1) ? 8'h40 : 8'h00);
      run(512, 0);
      chk(tg, (k == 1) ? 8 : 2);
    end
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
